// ---- xfer_buffer_pkg.sv ----
// Purpose: Shared constants and types for the transfer buffer block
// Assumes: 4-bit data memory nibbles, 16-bit program memory words
// Notes: Reset values of peripheral registers are plain zeros
package xfer_buffer_pkg;

   // ********************************************************
   // Widths
   // ********************************************************
   localparam int BUF_WIDTH = 16;
   localparam int NIBBLE_WIDTH = 4;
   localparam int NIBBLE_COUNT = 4;
   localparam int COMPARE_USED_BITS = 6;
   localparam int TABLE_ADDR_BITS = 13;
   localparam int TABLE_ADDR_BITS_SMALL = 8;
   localparam int CTL_DEPTH = 64;
   localparam int CTL_ADDR_BITS = 6;

   // ********************************************************
   // Data memory location of the transfer buffer
   // ********************************************************
   localparam logic [1:0] BUF_BANK = 2'h0;
   localparam logic [6:0] BUF_ADDR_HIGH = 7'h0c;
   localparam logic [6:0] BUF_ADDR_LOW = 7'h0f;

   // ********************************************************
   // Peripheral addresses
   // ********************************************************
   localparam logic [6:0] PADDR_COMPARE = 7'h02;
   localparam logic [6:0] PADDR_SERIAL = 7'h03;
   localparam logic [6:0] PADDR_PWM0 = 7'h05;
   localparam logic [6:0] PADDR_PWM1 = 7'h06;
   localparam logic [6:0] PADDR_TABLE_ADDR = 7'h40;
   localparam logic [6:0] PADDR_SYNTH = 7'h41;
   localparam logic [6:0] PADDR_KEY_SCAN = 7'h42;
   localparam logic [6:0] PADDR_FREQ = 7'h43;

   // ********************************************************
   // Reset values and read-back of undefined data
   // ********************************************************
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] UNDEF_WORD = 16'h0000;
   localparam logic [7:0] UNDEF_BYTE = 8'h00;
   localparam logic [3:0] UNDEF_NIBBLE = 4'h0;

   // Control register access maps, bit n for address n
   localparam logic [63:0] CTL_READABLE_MASK = 64'h00ff_00ff_00ff_00ff;
   localparam logic [63:0] CTL_WRITABLE_MASK = 64'h0000_ffff_0000_ffff;

   // ********************************************************
   // Pulse-width timing
   // ********************************************************
   localparam longint CLK_HZ = 250000000;
   localparam longint PWM_FREQ_MILLIHZ = 878900;
   localparam int PWM_PHASE_STEPS = 1024;
   localparam int PWM_STEP_CYCLES = int'((CLK_HZ * 1000) / (PWM_FREQ_MILLIHZ * PWM_PHASE_STEPS));

   typedef enum logic {TR_IDLE, TR_WAIT} table_state_e;

endpackage

// ---- ctl_nibble_mem.sv ----
// Purpose: Control register storage, one nibble per address
// Assumes: One write and one read port on the same clock
// Notes: Read data comes out of a register one cycle after the request
`timescale 1ns/100ps
module ctl_nibble_mem #(
   parameter int DEPTH = 64,
   parameter int ADDR_BITS = 6,
   parameter int WIDTH = 4
) (
   input wire logic core_clk,
   input wire logic wr_en,
   input wire logic [ADDR_BITS-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic rd_en,
   input wire logic [ADDR_BITS-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);

   logic [WIDTH-1:0] store_reg [DEPTH];

   if (DEPTH > (1 << ADDR_BITS)) begin : g_chk
      $error("ctl_nibble_mem: depth exceeds address range");
   end

   // Write port
   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         store_reg[wr_addr] <= wr_data;
      end
   end

   // Registered read port
   always_ff @(posedge core_clk) begin
      if (rd_en) begin
         rd_data <= store_reg[rd_addr];
      end
   end

endmodule

// ---- pulse_width_gen.sv ----
// Purpose: Pulse-width output driven by an 8-bit duty value
// Assumes: Duty value is stable or changes between periods
// Notes: Period is split in 1024 quarter steps; high for 4x+1 of them
`timescale 1ns/100ps
module pulse_width_gen #(
   parameter int STEP_CYCLES = xfer_buffer_pkg::PWM_STEP_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] duty_value,
   output logic pwm_out
);

   logic [9:0] prescale_reg;
   logic [9:0] phase_reg;
   logic [7:0] duty_shadow_reg;
   logic step_tick;
   logic [9:0] high_steps;

   if (STEP_CYCLES < 1 || STEP_CYCLES > 1023) begin : g_chk
      $error("pulse_width_gen: step count out of range");
   end

   // One tick per quarter step; high time is (x + 0.25)/256 of the period
   assign step_tick = (prescale_reg == 10'(STEP_CYCLES - 1));
   assign high_steps = {duty_shadow_reg, 2'b01};

   // Prescaler, phase and shadow duty taken at period start
   always_ff @(posedge core_clk) begin
      if (reset) begin
         prescale_reg <= 10'h000;
         phase_reg <= 10'h000;
         duty_shadow_reg <= xfer_buffer_pkg::RESET_BYTE;
         pwm_out <= 1'b0;
      end else begin
         prescale_reg <= step_tick ? 10'h000 : prescale_reg + 10'h001;
         if (step_tick) begin
            phase_reg <= phase_reg + 10'h001;
            if (phase_reg == 10'h3ff) begin
               duty_shadow_reg <= duty_value;
            end
         end
         pwm_out <= (phase_reg < high_steps);
      end
   end

endmodule

// ---- data_buffer_peripheral_access.sv ----
// Purpose: Transfer buffer between core, program memory and peripherals
// Assumes: Core issues one instruction request at a time on core_clk
// Notes: Undefined read data is a fixed constant from the package
//
// Contract
// RL1: Write-only control register reads return undefined
// RL2: Writes to read-only control registers ignored
// RL3: Unused control register reads return undefined
// RL4: Writes to unused control addresses ignored
// RL5: Buffer is 16 bits, bank0 0CH-0FH
// RL6: 0CH bit3 is MSB, 0FH bit0 LSB
// RL7: Data memory instructions reach buffer nibbles
// RL8: Table read loads program word into buffer
// RL9: Table read holds one stack level
// RL10: Small variant table read reaches 0000H-00FFH
// RL11: Peripheral load copies register into buffer
// RL12: Peripheral store copies buffer into register
// RL13: Compare value at 02H, 8-bit, 6 used
// RL14: Serial shift at 03H, 8-bit both ways
// RL15: Pulse width 0 at 05H; 06H unreachable
// RL16: Pulse width high fraction (x+0.25)/256
// RL17: Table address at 40H, 13 bits used
// RL18: Synth divide ratio at 41H, 16 bits
// RL19: Key scan output at 42H, 16 bits
// RL20: Frequency count at 43H, read only
// RL21: Small variant table address uses 8 bits
// RL22: Byte transfers use low byte only
`timescale 1ns/100ps
module data_buffer_peripheral_access #(
   parameter bit SMALL_VARIANT = 1'b0,
   parameter int ROM_ADDR_BITS = xfer_buffer_pkg::TABLE_ADDR_BITS,
   parameter logic [63:0] CTL_READABLE = xfer_buffer_pkg::CTL_READABLE_MASK,
   parameter logic [63:0] CTL_WRITABLE = xfer_buffer_pkg::CTL_WRITABLE_MASK
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [1:0] dm_bank,
   input wire logic [6:0] dm_addr,
   input wire logic dm_wr,
   input wire logic [3:0] dm_wdata,
   input wire logic dm_rd,
   output logic dm_hit,
   output logic [3:0] dm_rdata,
   input wire logic [5:0] ctl_addr,
   input wire logic ctl_wr,
   input wire logic [3:0] ctl_wdata,
   input wire logic ctl_rd,
   output logic [3:0] ctl_rdata,
   input wire logic [6:0] per_addr,
   input wire logic per_load,
   input wire logic per_store,
   input wire logic table_read,
   output logic table_busy,
   output logic stack_level_claim,
   output logic rom_rd,
   output logic [12:0] rom_addr,
   input wire logic [15:0] rom_data,
   input wire logic rom_valid,
   output logic [15:0] transfer_buffer,
   output logic [5:0] converter_compare_value,
   output logic [7:0] serial_tx_data,
   output logic serial_tx_load,
   input wire logic [7:0] serial_rx_data,
   output logic [15:0] synth_divide_ratio,
   output logic [15:0] key_scan_output,
   input wire logic [15:0] freq_count_result,
   output logic pwm_out
);

   // ********************************************************
   // Declarations
   // ********************************************************
   localparam int TA_BITS = xfer_buffer_pkg::TABLE_ADDR_BITS;
   localparam int TA_USED = SMALL_VARIANT ? xfer_buffer_pkg::TABLE_ADDR_BITS_SMALL : TA_BITS;
   localparam logic [12:0] TA_MASK = 13'((1 << TA_USED) - 1);

   logic [15:0] transfer_buffer_reg;
   logic [15:0] transfer_buffer_next;
   logic [5:0] compare_reg;
   logic [7:0] serial_tx_reg;
   logic serial_load_reg;
   logic [7:0] pwm0_reg;
   logic [12:0] table_address_reg;
   logic [15:0] synth_reg;
   logic [15:0] key_scan_reg;
   logic [12:0] rom_addr_reg;
   logic [3:0] dm_rdata_reg;
   logic ctl_read_ok_reg;
   xfer_buffer_pkg::table_state_e table_state_reg;
   xfer_buffer_pkg::table_state_e table_state_next;
   logic buf_hit;
   logic [1:0] nibble_index;
   logic [3:0] buf_nibble;
   logic table_accept;
   logic table_done;
   logic get_now;
   logic put_now;
   logic [15:0] per_rdata;
   logic [7:0] low_byte;
   logic ctl_wr_ok;
   logic ctl_rd_ok;
   logic [3:0] ctl_mem_rdata;
   logic [12:0] ta_masked;

   if (ROM_ADDR_BITS != TA_BITS) begin : g_chk
      $error("data_buffer_peripheral_access: program address width must match table address");
   end

   // ********************************************************
   // Data memory side of the buffer
   // ********************************************************
   // RL5: bank 0 decode
   assign buf_hit = (dm_bank == xfer_buffer_pkg::BUF_BANK) &&
                    (dm_addr >= xfer_buffer_pkg::BUF_ADDR_HIGH) &&
                    (dm_addr <= xfer_buffer_pkg::BUF_ADDR_LOW);
   // RL6: 0CH maps to bits 15:12
   assign nibble_index = 2'(xfer_buffer_pkg::BUF_ADDR_LOW - dm_addr);
   assign buf_nibble = transfer_buffer_reg[nibble_index*4 +: 4];
   assign dm_hit = buf_hit;

   // ********************************************************
   // Instruction decode
   // ********************************************************
   assign table_accept = table_read && (table_state_reg == xfer_buffer_pkg::TR_IDLE);
   assign table_done = (table_state_reg == xfer_buffer_pkg::TR_WAIT) && rom_valid;
   assign get_now = per_load && (table_state_reg == xfer_buffer_pkg::TR_IDLE);
   assign put_now = per_store && (table_state_reg == xfer_buffer_pkg::TR_IDLE);
   assign low_byte = transfer_buffer_reg[7:0];
   // RL21: small variant keeps 8 address bits
   assign ta_masked = transfer_buffer_reg[12:0] & TA_MASK;

   // ********************************************************
   // Peripheral read selection
   // ********************************************************
   // RL11: selected register feeds the load
   // RL22: upper byte undefined on byte reads
   // RL15: address 06H falls to undefined
   assign per_rdata =
      (per_addr == xfer_buffer_pkg::PADDR_COMPARE) ? {xfer_buffer_pkg::UNDEF_BYTE, 2'b00, compare_reg} :
      (per_addr == xfer_buffer_pkg::PADDR_SERIAL) ? {xfer_buffer_pkg::UNDEF_BYTE, serial_rx_data} :
      (per_addr == xfer_buffer_pkg::PADDR_PWM0) ? {xfer_buffer_pkg::UNDEF_BYTE, pwm0_reg} :
      (per_addr == xfer_buffer_pkg::PADDR_TABLE_ADDR) ? {3'b000, table_address_reg} :
      (per_addr == xfer_buffer_pkg::PADDR_SYNTH) ? synth_reg :
      (per_addr == xfer_buffer_pkg::PADDR_KEY_SCAN) ? key_scan_reg :
      (per_addr == xfer_buffer_pkg::PADDR_FREQ) ? freq_count_result :
      xfer_buffer_pkg::UNDEF_WORD;

   // ********************************************************
   // Buffer next value, one nibble per generate pass
   // ********************************************************
   for (genvar n = 0; n < xfer_buffer_pkg::NIBBLE_COUNT; n++) begin : g_nibble
      always_comb begin
         // RL8: program word into buffer
         if (table_done) begin
            transfer_buffer_next[n*4 +: 4] = rom_data[n*4 +: 4];
         // RL11: peripheral load
         end else if (get_now) begin
            transfer_buffer_next[n*4 +: 4] = per_rdata[n*4 +: 4];
         // RL7: data memory write reaches nibble
         end else if (dm_wr && buf_hit && (nibble_index == 2'(n))) begin
            transfer_buffer_next[n*4 +: 4] = dm_wdata;
         end else begin
            transfer_buffer_next[n*4 +: 4] = transfer_buffer_reg[n*4 +: 4];
         end
      end
   end

   // Buffer and data memory read register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         transfer_buffer_reg <= xfer_buffer_pkg::RESET_WORD;
         dm_rdata_reg <= 4'h0;
      end else begin
         transfer_buffer_reg <= transfer_buffer_next;
         // RL7: data memory read of nibble
         if (dm_rd && buf_hit) begin
            dm_rdata_reg <= buf_nibble;
         end
      end
   end

   // ********************************************************
   // Peripheral registers written by the store
   // ********************************************************
   // RL12: buffer into selected register
   // RL13: 6 used bits of compare
   // RL14: serial outgoing byte
   // RL17: table address from buffer
   // RL18: all 16 bits of ratio
   // RL19: all 16 bits of key scan
   // RL20: frequency count has no write
   always_ff @(posedge core_clk) begin
      if (reset) begin
         compare_reg <= 6'h00;
         serial_tx_reg <= xfer_buffer_pkg::RESET_BYTE;
         serial_load_reg <= 1'b0;
         pwm0_reg <= xfer_buffer_pkg::RESET_BYTE;
         table_address_reg <= 13'h0000;
         synth_reg <= xfer_buffer_pkg::RESET_WORD;
         key_scan_reg <= xfer_buffer_pkg::RESET_WORD;
      end else begin
         serial_load_reg <= put_now && (per_addr == xfer_buffer_pkg::PADDR_SERIAL);
         if (put_now) begin
            unique case (per_addr)
               xfer_buffer_pkg::PADDR_COMPARE: compare_reg <= low_byte[5:0];
               xfer_buffer_pkg::PADDR_SERIAL: serial_tx_reg <= low_byte;
               xfer_buffer_pkg::PADDR_PWM0: pwm0_reg <= low_byte;
               xfer_buffer_pkg::PADDR_TABLE_ADDR: table_address_reg <= ta_masked;
               xfer_buffer_pkg::PADDR_SYNTH: synth_reg <= transfer_buffer_reg;
               xfer_buffer_pkg::PADDR_KEY_SCAN: key_scan_reg <= transfer_buffer_reg;
               default: ;
            endcase
         end
      end
   end

   // ********************************************************
   // Table read sequence
   // ********************************************************
   // Next state of the fetch
   always_comb begin
      table_state_next = table_state_reg;
      unique case (table_state_reg)
         xfer_buffer_pkg::TR_IDLE: begin
            if (table_read) begin
               table_state_next = xfer_buffer_pkg::TR_WAIT;
            end
         end
         xfer_buffer_pkg::TR_WAIT: begin
            if (rom_valid) begin
               table_state_next = xfer_buffer_pkg::TR_IDLE;
            end
         end
      endcase
   end

   // State and latched program address
   always_ff @(posedge core_clk) begin
      if (reset) begin
         table_state_reg <= xfer_buffer_pkg::TR_IDLE;
         rom_addr_reg <= 13'h0000;
      end else begin
         table_state_reg <= table_state_next;
         // RL10: small variant stays below 0100H
         if (table_accept) begin
            rom_addr_reg <= table_address_reg & TA_MASK;
         end
      end
   end

   // RL9: stack level held during fetch
   assign stack_level_claim = (table_state_reg == xfer_buffer_pkg::TR_WAIT);
   assign table_busy = (table_state_reg == xfer_buffer_pkg::TR_WAIT);
   assign rom_rd = (table_state_reg == xfer_buffer_pkg::TR_WAIT);

   // ********************************************************
   // Control register file
   // ********************************************************
   // RL2: read-only write blocked
   // RL4: unused write blocked
   assign ctl_wr_ok = ctl_wr && CTL_WRITABLE[ctl_addr];
   assign ctl_rd_ok = CTL_READABLE[ctl_addr];

   ctl_nibble_mem #(
      .DEPTH(xfer_buffer_pkg::CTL_DEPTH),
      .ADDR_BITS(xfer_buffer_pkg::CTL_ADDR_BITS),
      .WIDTH(xfer_buffer_pkg::NIBBLE_WIDTH)
   ) u_ctl_mem (
      .core_clk(core_clk),
      .wr_en(ctl_wr_ok),
      .wr_addr(ctl_addr),
      .wr_data(ctl_wdata),
      .rd_en(ctl_rd),
      .rd_addr(ctl_addr),
      .rd_data(ctl_mem_rdata)
   );

   // Remember whether the pending read may show stored data
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctl_read_ok_reg <= 1'b0;
      end else if (ctl_rd) begin
         ctl_read_ok_reg <= ctl_rd_ok;
      end
   end

   // RL1: write-only reads undefined
   // RL3: unused reads undefined
   assign ctl_rdata = ctl_read_ok_reg ? ctl_mem_rdata : xfer_buffer_pkg::UNDEF_NIBBLE;

   // ********************************************************
   // Pulse-width output
   // ********************************************************
   // RL16: duty (x+0.25)/256
   pulse_width_gen #(
      .STEP_CYCLES(xfer_buffer_pkg::PWM_STEP_CYCLES)
   ) u_pwm0 (
      .core_clk(core_clk),
      .reset(reset),
      .duty_value(pwm0_reg),
      .pwm_out(pwm_out)
   );

   // ********************************************************
   // Outputs
   // ********************************************************
   assign dm_rdata = dm_rdata_reg;
   assign rom_addr = rom_addr_reg;
   assign transfer_buffer = transfer_buffer_reg;
   assign converter_compare_value = compare_reg;
   assign serial_tx_data = serial_tx_reg;
   assign serial_tx_load = serial_load_reg;
   assign synth_divide_ratio = synth_reg;
   assign key_scan_output = key_scan_reg;

endmodule

// ---- prog_mem_model.sv ----
// Purpose: Program memory that answers table fetches
// Assumes: Fetch request is a level held until the reply
// Notes: Reply word is 3'h5 above the 13-bit address
`timescale 1ns/100ps
module prog_mem_model #(
   parameter int LAT = 3
) (
   input logic core_clk,
   input logic rom_rd,
   input logic [12:0] rom_addr,
   output logic [15:0] rom_data,
   output logic rom_valid
);
   // ****************************************
   // Reply logic
   // ****************************************
   int wait_cnt = 0;
   initial rom_data = 16'h0000;
   initial rom_valid = 1'b0;
   always @(posedge core_clk) begin
      rom_valid <= 1'b0;
      rom_data <= rom_data + 16'h1111; // Noise while idle
      if (rom_rd && !rom_valid) begin
         wait_cnt <= wait_cnt + 1;
         if (wait_cnt == LAT) begin
            rom_valid <= 1'b1;
            rom_data <= {3'h5, rom_addr};
            wait_cnt <= 0;
         end
      end
   end
endmodule

// ---- data_buffer_peripheral_access_monitor.sv ----
// Purpose: Port checks for the transfer buffer block
// Assumes: One clock, synchronous active-high reset
// Notes: Attached by bind at the foot of this file
`timescale 1ns/100ps
module buffer_access_monitor (
   input logic core_clk,
   input logic reset,
   input logic [1:0] dm_bank,
   input logic [6:0] dm_addr,
   input logic dm_wr,
   input logic [3:0] dm_wdata,
   input logic dm_hit,
   input logic [6:0] per_addr,
   input logic per_load,
   input logic per_store,
   input logic table_read,
   input logic table_busy,
   input logic stack_level_claim,
   input logic rom_rd,
   input logic [15:0] rom_data,
   input logic rom_valid,
   input logic [15:0] transfer_buffer,
   input logic serial_tx_load,
   input logic [15:0] synth_divide_ratio,
   input logic [15:0] freq_count_result
);
   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);
   chk_hit_decode: assert property (
      dm_hit == (dm_bank == 2'h0 && dm_addr >= 7'h0c && dm_addr <= 7'h0f))
      else $error("buffer hit decode wrong");
   chk_stack_claim: assert property (
      stack_level_claim == table_busy && rom_rd == table_busy)
      else $error("stack claim differs from busy");
   chk_table_start: assert property (
      table_read && !table_busy |=> table_busy[*2])
      else $error("table read did not start");
   chk_table_load: assert property (
      table_busy && rom_valid |=> !table_busy && transfer_buffer == $past(rom_data))
      else $error("program word not loaded");
   chk_nibble_high: assert property (
      dm_wr && dm_hit && dm_addr == 7'h0c && !per_load && !table_busy
      |=> transfer_buffer[15:12] == $past(dm_wdata))
      else $error("high nibble write lost");
   chk_synth_store: assert property (
      per_store && per_addr == 7'h41 && !table_busy |=> synth_divide_ratio == $past(transfer_buffer))
      else $error("divide ratio store wrong");
   chk_synth_hold: assert property (
      !(per_store && per_addr == 7'h41) |=> $stable(synth_divide_ratio))
      else $error("divide ratio changed unasked");
   chk_freq_load: assert property (
      per_load && per_addr == 7'h43 && !table_busy |=> transfer_buffer == $past(freq_count_result))
      else $error("count load wrong");
   chk_serial_pulse: assert property (
      per_store && per_addr == 7'h03 && !table_busy |=> serial_tx_load ##1 !serial_tx_load)
      else $error("serial load pulse missing");
endmodule
bind data_buffer_peripheral_access buffer_access_monitor i_buffer_access_monitor (
   .core_clk, .reset, .dm_bank, .dm_addr, .dm_wr, .dm_wdata, .dm_hit, .per_addr, .per_load,
   .per_store, .table_read, .table_busy, .stack_level_claim, .rom_rd, .rom_data, .rom_valid,
   .transfer_buffer, .serial_tx_load, .synth_divide_ratio, .freq_count_result);

// ---- test_data_buffer_peripheral_access.sv ----
// Purpose: Self-checking bench for the transfer buffer block
// Assumes: Inputs change on the falling edge of core_clk
// Notes: Pulse-width check runs first, while the duty is still zero
`timescale 1ns/100ps
module test_data_buffer_peripheral_access;
   // ****************************************
   // Signals and instances
   // ****************************************
   logic core_clk = 0, reset = 1, dm_wr = 0, dm_rd = 0, ctl_wr = 0, ctl_rd = 0;
   logic per_load = 0, per_store = 0, table_read = 0;
   logic [1:0] dm_bank = 0;
   logic [6:0] dm_addr = 0, per_addr = 0;
   logic [3:0] dm_wdata = 0, ctl_wdata = 0, dm_rdata, ctl_rdata;
   logic [5:0] ctl_addr = 0, converter_compare_value;
   logic [7:0] serial_rx_data = 8'h3c, serial_tx_data;
   logic [15:0] freq_count_result = 16'h9abc, rom_data, transfer_buffer, synth_divide_ratio, key_scan_output;
   logic [12:0] rom_addr;
   logic dm_hit, table_busy, stack_level_claim, rom_rd, rom_valid, serial_tx_load, pwm_out;
   int bad_count = 0;
   int checks = 0;
   always #2 core_clk = ~core_clk;
   data_buffer_peripheral_access i_data_buffer_peripheral_access (
      .core_clk, .reset, .dm_bank, .dm_addr, .dm_wr, .dm_wdata, .dm_rd, .dm_hit, .dm_rdata,
      .ctl_addr, .ctl_wr, .ctl_wdata, .ctl_rd, .ctl_rdata, .per_addr, .per_load, .per_store,
      .table_read, .table_busy, .stack_level_claim, .rom_rd, .rom_addr, .rom_data, .rom_valid,
      .transfer_buffer, .converter_compare_value, .serial_tx_data, .serial_tx_load,
      .serial_rx_data, .synth_divide_ratio, .key_scan_output, .freq_count_result, .pwm_out);
   prog_mem_model i_prog_mem_model (.core_clk, .rom_rd, .rom_addr, .rom_data, .rom_valid);
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic dm_acc(input logic [6:0] a, input logic w, input logic [3:0] d);
      @(negedge core_clk);
      dm_addr = a; dm_wr = w; dm_rd = !w; dm_wdata = d;
      @(negedge core_clk);
      dm_wr = 0; dm_rd = 0; dm_wdata = ~d;
   endtask
   task automatic ctl_acc(input logic [5:0] a, input logic w, input logic [3:0] d);
      @(negedge core_clk);
      ctl_addr = a; ctl_wr = w; ctl_rd = !w; ctl_wdata = d;
      @(negedge core_clk);
      ctl_wr = 0; ctl_rd = 0;
   endtask
   task automatic set_buf(input logic [15:0] v);
      for (int i = 0; i < 4; i++) dm_acc(7'(7'h0c + i), 1'b1, v[15 - 4 * i -: 4]);
   endtask
   task automatic per_op(input logic [6:0] a, input logic st);
      @(negedge core_clk);
      per_addr = a; per_store = st; per_load = !st;
      @(negedge core_clk);
      per_store = 0; per_load = 0;
   endtask
   task automatic per_rt(input logic [6:0] a, input logic [15:0] w, input logic [15:0] e);
      set_buf(w);
      per_op(a, 1'b1);
      set_buf(16'hc3c3);
      per_op(a, 1'b0);
      chk("peripheral read back", e, transfer_buffer);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_pwm();
      int n;
      n = 0;
      @(negedge core_clk);
      chk("pulse high at duty zero", 16'h0001, {15'h0, pwm_out});
      while (pwm_out === 1'b1 && n < 400) begin
         @(negedge core_clk);
         n++;
      end
      chk("pulse high cycles", 16'(xfer_buffer_pkg::PWM_STEP_CYCLES), 16'(n));
      if (n == 400) close_out();
      $display("test pulse done");
   endtask
   task automatic t_buffer();
      chk("buffer after reset", 16'h0000, transfer_buffer);
      set_buf(16'h1234);
      chk("buffer nibble order", 16'h1234, transfer_buffer);
      dm_acc(7'h0d, 1'b0, 4'h0);
      chk("nibble read", 16'h0002, {12'h000, dm_rdata});
      dm_bank = 2'h1;
      dm_acc(7'h0c, 1'b1, 4'hf);
      dm_bank = 2'h0;
      chk("other bank ignored", 16'h1234, transfer_buffer);
      $display("test buffer done");
   endtask
   task automatic t_ctl();
      ctl_acc(6'h01, 1'b1, 4'h5);
      ctl_acc(6'h01, 1'b0, 4'h0);
      chk("control read write", 16'h0005, {12'h000, ctl_rdata});
      ctl_acc(6'h09, 1'b1, 4'ha);
      ctl_acc(6'h09, 1'b0, 4'h0);
      chk("write only read", {12'h000, xfer_buffer_pkg::UNDEF_NIBBLE}, {12'h000, ctl_rdata});
      ctl_acc(6'h19, 1'b1, 4'ha);
      ctl_acc(6'h19, 1'b0, 4'h0);
      chk("unused read", {12'h000, xfer_buffer_pkg::UNDEF_NIBBLE}, {12'h000, ctl_rdata});
      ctl_acc(6'h11, 1'b1, 4'ha);
      ctl_acc(6'h11, 1'b0, 4'h0);
      checks++;
      if (ctl_rdata === 4'ha) begin
         bad_count++;
         $display("CHECK FAILED read only write expected not a seen %h", ctl_rdata);
      end
      $display("test control done");
   endtask
   task automatic t_periph();
      per_rt(7'h02, 16'hffff, 16'h003f);
      per_rt(7'h03, 16'h12a5, 16'h003c);
      per_rt(7'h05, 16'hff5a, 16'h005a);
      per_rt(7'h06, 16'h7777, xfer_buffer_pkg::UNDEF_WORD);
      per_rt(7'h40, 16'hffff, 16'h1fff);
      per_rt(7'h41, 16'hbeef, 16'hbeef);
      per_rt(7'h42, 16'h1357, 16'h1357);
      per_rt(7'h43, 16'h1111, 16'h9abc);
      per_rt(7'h10, 16'h2468, xfer_buffer_pkg::UNDEF_WORD);
      chk("compare port", 16'h003f, {10'h000, converter_compare_value});
      chk("serial out port", 16'h00a5, {8'h00, serial_tx_data});
      chk("divide port", 16'hbeef, synth_divide_ratio);
      chk("key scan port", 16'h1357, key_scan_output);
      $display("test peripheral done");
   endtask
   task automatic t_table();
      int n;
      set_buf(16'hf234);
      per_op(7'h40, 1'b1);
      @(negedge core_clk);
      table_read = 1;
      @(negedge core_clk);
      table_read = 0; per_addr = 7'h43; per_load = 1;
      @(negedge core_clk);
      per_load = 0;
      chk("busy claims stack", 16'h0001, {15'h0, stack_level_claim});
      n = 0;
      while (table_busy !== 1'b0 && n < 20) begin
         @(negedge core_clk);
         n++;
      end
      if (n == 20) begin
         bad_count++;
         $display("CHECK FAILED table busy expected 0 seen %b", table_busy);
         close_out();
      end
      chk("fetch address", 16'h1234, {3'h0, rom_addr});
      chk("table word", 16'hb234, transfer_buffer);
      $display("test table done");
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      repeat (12) @(negedge core_clk);
      reset = 0;
      t_pwm();
      t_buffer();
      t_ctl();
      t_periph();
      t_table();
      close_out();
   end
endmodule
